/* logic/pds_digit_shifter.v */
/*
 * Display register and two-rank digit counter.
 * Assumes the sequencer issues at most one operation per cycle; clear wins.
 */
`include "pds_map.vh"

module pds_digit_shifter (
	// Clock and reset
	input wire core_clk,
	input wire resetn,
	// Operations
	input wire load,
	input wire [31:0] load_data,
	input wire clear,
	input wire copy_rank,
	input wire advance,
	// State
	output wire [3:0] top_digit,
	output wire [2:0] count,
	output wire [31:0] disp
);

	reg [31:0] dr_q;
	reg [2:0] rank1_q;
	reg [2:0] rank2_q;
	wire [2:0] next_cnt;

	assign next_cnt = rank1_q + 3'h1;
	assign top_digit = dr_q[31:28];
	assign count = rank2_q;
	assign disp = dr_q;

	always @(posedge core_clk) begin
		if (!resetn || clear) begin
			dr_q <= 32'h0000_0000;
			rank1_q <= `PDS_CNT_ZERO;
			rank2_q <= `PDS_CNT_ZERO;
		end else if (load) begin
			dr_q <= load_data;
			rank1_q <= `PDS_CNT_ZERO;
			rank2_q <= `PDS_CNT_ZERO;
		end else if (advance) begin
			rank2_q <= next_cnt;
			// Next lower group moves into the top four stages
			if (next_cnt != `PDS_CNT_ZERO) begin
				dr_q[31:28] <= dr_q[31 - 4 * next_cnt -: 4];
			end
		end else if (copy_rank) begin
			rank1_q <= rank2_q;
		end
	end

endmodule // pds_digit_shifter

/* logic/pds_map.vh */
/*
 * Constants of the printer digit sequencer: register offsets, field positions,
 * reset values, display modes and timing counts.
 * Assumes a 250 MHz core clock and a byte-addressed 32-bit register port.
 */
`ifndef PDS_MAP_VH
`define PDS_MAP_VH

// Clock rate and pacing oscillator half period (10 cps nominal)
`define PDS_CLK_KHZ 250000
`define PDS_PACE_HALF_MS 50
`define PDS_PACE_HALF_CYC (`PDS_PACE_HALF_MS * `PDS_CLK_KHZ)

// Register offsets
`define PDS_REG_CTRL 8'h00
`define PDS_REG_PACE 8'h04
`define PDS_REG_STAT 8'h08
`define PDS_REG_DISP 8'h0c

// Control register fields
`define PDS_CTRL_MAINT 0
`define PDS_CTRL_HOLD 1
`define PDS_CTRL_RST 32'h0000_0000

// Status register fields
`define PDS_ST_INIT 0
`define PDS_ST_BUSY 1
`define PDS_ST_SYNC 2
`define PDS_ST_STEP1 3
`define PDS_ST_STEP2 4
`define PDS_ST_STEP3 5
`define PDS_ST_XLAT 6
`define PDS_ST_DELAY 7
`define PDS_ST_STRIKE 8
`define PDS_ST_RES 9
`define PDS_ST_CNT_LSB 12

// Display modes
`define PDS_MODE_TGT 3'h1
`define PDS_MODE_DEC 3'h2
`define PDS_MODE_OCT 3'h3
`define PDS_MODE_SPACE 3'h4
`define PDS_MODE_MISS 3'h5

// Counter values
`define PDS_CNT_LAST 3'h7
`define PDS_CNT_ZERO 3'h0

// Machine phase numbers
`define PDS_MP_ZERO 0
`define PDS_MP_CLEAR 1
`define PDS_MP_INIT 2
`define PDS_MP_BUSY 6

`endif

/* logic/pds_phase_gen.v */
/*
 * Phase generator: alternating CP0/CP1 enables, eight machine phase strobes
 * and the slow pacing oscillator level.
 * Assumes one core clock; all outputs are enables or levels on that clock.
 */
`include "pds_map.vh"

module pds_phase_gen #(
	parameter CNT_W = 32
) (
	// Clock and reset
	input wire core_clk,
	input wire resetn,
	// Pacing half period in core cycles
	input wire [CNT_W-1:0] pace_half,
	// Phase outputs
	output wire cp0,
	output wire cp1,
	output wire [7:0] mp_pulse,
	output wire pace_level
);

	reg cp1_q;
	reg [2:0] mp_q;
	reg [CNT_W-1:0] pace_cnt_q;
	reg pace_q;
	wire pace_end;

	assign cp0 = ~cp1_q;
	assign cp1 = cp1_q;
	// Machine phase strobes land on CP0 cycles only
	assign mp_pulse = cp0 ? (8'h01 << mp_q) : 8'h00;
	assign pace_level = pace_q;
	assign pace_end = (pace_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}) >= pace_half;

	always @(posedge core_clk) begin
		if (!resetn) begin
			cp1_q <= 1'b0;
			mp_q <= 3'h0;
			pace_cnt_q <= {CNT_W{1'b0}};
			pace_q <= 1'b0;
		end else begin
			cp1_q <= ~cp1_q;
			if (cp1_q) begin
				mp_q <= mp_q + 3'h1;
			end
			if (pace_end) begin
				pace_cnt_q <= {CNT_W{1'b0}};
				pace_q <= ~pace_q;
			end else begin
				pace_cnt_q <= pace_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // pds_phase_gen

/* logic/pds_sequencer.v */
/*
 * Printer digit sequencer: paces eight digits from the display register to
 * the digit printer, fires the strike solenoid, runs the resume handshake,
 * handles line space and interruption by plot or the target and miss display modes.
 * Assumes printer resume inputs and instruction strobes are synchronous to
 * core_clk; register port strobes are one cycle long.
 */
// Our own choices: the address-and-strobe port and the register offsets.

`include "pds_map.vh"

module pds_sequencer #(
	parameter PACE_HALF = `PDS_PACE_HALF_CYC
) (
	// Clock and reset
	input wire core_clk,
	input wire resetn,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Display instruction and plot from command decode
	input wire display_instruction,
	input wire [2:0] display_mode,
	input wire [31:0] display_data,
	input wire plot_instruction,
	// Program sync
	input wire wait_halt,
	output wire print_sync_n,
	// Printer
	input wire resume_start,
	input wire resume_idle,
	output reg [3:0] digit_out,
	output reg digit_valid,
	output wire solenoid
);

	reg [31:0] ctrl_q;
	reg [31:0] pace_q;
	reg init_q;
	reg busy_q;
	reg sync_q;
	reg step1_q;
	reg step2_q;
	reg step3_q;
	reg xlat_q;
	reg delay_q;
	reg strike_q;
	reg res_q;
	reg pace_prev_q;
	reg rise_pend_q;
	reg fall_pend_q;
	reg req_q;
	reg [2:0] req_mode_q;
	reg [31:0] req_data_q;
	reg abort_q;
	wire cp0;
	wire cp1;
	wire [7:0] mp_pulse;
	wire pace_level;
	wire [3:0] top_digit;
	wire [2:0] count;
	wire [31:0] disp;
	wire start_req;
	wire start_now;
	wire abort_now;
	wire sh_load;
	wire sh_copy;
	wire sh_adv;
	wire maint_ok;
	wire [31:0] status;

	// Octal data is spread: every fourth stage left clear
	function [31:0] spread;
		input [23:0] v;
		integer i;
		begin
			spread = 32'h0000_0000;
			for (i = 0; i < 8; i = i + 1) begin
				spread[4 * i +: 3] = v[3 * i +: 3];
			end
		end
	endfunction

	pds_phase_gen #(
		.CNT_W(32)
	) u_phase (
		.core_clk(core_clk),
		.resetn(resetn),
		.pace_half(pace_q),
		.cp0(cp0),
		.cp1(cp1),
		.mp_pulse(mp_pulse),
		.pace_level(pace_level)
	);

	pds_digit_shifter u_shift (
		.core_clk(core_clk),
		.resetn(resetn),
		.load(sh_load),
		.load_data(req_data_q),
		.clear(abort_now),
		.copy_rank(sh_copy),
		.advance(sh_adv),
		.top_digit(top_digit),
		.count(count),
		.disp(disp)
	);

	// Initiation and interruption decode
	assign start_req = req_q && (req_mode_q == `PDS_MODE_DEC || req_mode_q == `PDS_MODE_OCT
		|| req_mode_q == `PDS_MODE_SPACE);
	assign start_now = start_req && mp_pulse[`PDS_MP_INIT] && !busy_q && !init_q;
	assign abort_now = abort_q && mp_pulse[`PDS_MP_CLEAR] && init_q;
	assign sh_load = start_now && req_mode_q != `PDS_MODE_SPACE;
	// Counter steps are held off for the first digit
	assign sh_adv = cp0 && step1_q && delay_q && !abort_now;
	assign sh_copy = cp1 && step2_q && !strike_q && !abort_now;

	assign solenoid = strike_q && !res_q;
	assign maint_ok = ctrl_q[`PDS_CTRL_MAINT] || ctrl_q[`PDS_CTRL_HOLD];
	assign print_sync_n = ~(!init_q && res_q && wait_halt && maint_ok);

	// Pacing edges are held until the matching clock phase
	always @(posedge core_clk) begin
		if (!resetn) begin
			pace_prev_q <= 1'b0;
			rise_pend_q <= 1'b0;
			fall_pend_q <= 1'b0;
		end else begin
			pace_prev_q <= pace_level;
			if (pace_level && !pace_prev_q) begin
				rise_pend_q <= 1'b1;
			end else if (cp0) begin
				rise_pend_q <= 1'b0;
			end
			if (!pace_level && pace_prev_q) begin
				fall_pend_q <= 1'b1;
			end else if (cp1) begin
				fall_pend_q <= 1'b0;
			end
		end
	end

	// Instruction capture until its machine phase comes round
	always @(posedge core_clk) begin
		if (!resetn) begin
			req_q <= 1'b0;
			req_mode_q <= 3'h0;
			req_data_q <= 32'h0000_0000;
			abort_q <= 1'b0;
		end else begin
			if (display_instruction) begin
				req_q <= 1'b1;
				req_mode_q <= display_mode;
				req_data_q <= (display_mode == `PDS_MODE_OCT) ?
					spread(display_data[23:0]) : display_data;
			end else if (mp_pulse[`PDS_MP_INIT]) begin
				req_q <= 1'b0;
			end
			if (plot_instruction || (display_instruction
				&& (display_mode == `PDS_MODE_TGT || display_mode == `PDS_MODE_MISS))) begin
				abort_q <= 1'b1;
			end else if (mp_pulse[`PDS_MP_CLEAR]) begin
				abort_q <= 1'b0;
			end
		end
	end

	// Print control flags
	always @(posedge core_clk) begin
		if (!resetn) begin
			init_q <= 1'b0;
			busy_q <= 1'b0;
			sync_q <= 1'b0;
			step1_q <= 1'b0;
			step2_q <= 1'b0;
			step3_q <= 1'b0;
			xlat_q <= 1'b0;
			delay_q <= 1'b0;
			strike_q <= 1'b0;
			res_q <= 1'b0;
		end else if (abort_now) begin
			// Partial word printed, sequencing flags dropped
			sync_q <= 1'b0;
			step1_q <= 1'b0;
			step2_q <= 1'b0;
			step3_q <= 1'b0;
			xlat_q <= 1'b0;
			delay_q <= 1'b0;
			strike_q <= 1'b1;
		end else begin
			if (start_now) begin
				init_q <= 1'b1;
				if (req_mode_q == `PDS_MODE_SPACE) begin
					strike_q <= 1'b1;
				end
			end
			if (mp_pulse[`PDS_MP_BUSY] && init_q) begin
				busy_q <= 1'b1;
			end
			if (mp_pulse[`PDS_MP_ZERO] && !init_q && !res_q && !strike_q) begin
				busy_q <= 1'b0;
			end
			if (resume_start && strike_q) begin
				res_q <= 1'b1;
			end
			if (cp0) begin
				if (rise_pend_q && init_q && !strike_q) begin
					sync_q <= 1'b1;
					xlat_q <= 1'b0;
				end else if (step1_q) begin
					sync_q <= 1'b0;
				end
				if (step1_q) begin
					step2_q <= 1'b1;
				end else if (step2_q) begin
					step2_q <= 1'b0;
				end
				if (step2_q && step3_q) begin
					xlat_q <= 1'b1;
				end
				if (!init_q && res_q) begin
					res_q <= 1'b0;
					strike_q <= 1'b0;
					delay_q <= 1'b0;
				end
			end
			if (cp1) begin
				if (fall_pend_q && sync_q && init_q && !strike_q && !step1_q) begin
					step1_q <= 1'b1;
					if (count == `PDS_CNT_LAST && delay_q) begin
						strike_q <= 1'b1;
					end
				end else if (step1_q) begin
					step1_q <= 1'b0;
				end
				if (step2_q && !strike_q) begin
					step3_q <= 1'b1;
				end else if (xlat_q) begin
					step3_q <= 1'b0;
				end
				if (xlat_q) begin
					delay_q <= 1'b1;
				end
				if (resume_idle && res_q) begin
					init_q <= 1'b0;
				end
			end
		end
	end

	// Digit presented to the printer
	always @(posedge core_clk) begin
		if (!resetn) begin
			digit_out <= 4'h0;
			digit_valid <= 1'b0;
		end else begin
			digit_valid <= xlat_q;
			digit_out <= xlat_q ? top_digit : 4'h0;
		end
	end

	assign status = {17'h0_0000, count, 2'h0, res_q, strike_q, delay_q, xlat_q,
		step3_q, step2_q, step1_q, sync_q, busy_q, init_q};

	// Register port
	always @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_q <= `PDS_CTRL_RST;
			pace_q <= PACE_HALF;
			reg_rdata <= 32'h0000_0000;
		end else begin
			if (reg_wr && reg_addr == `PDS_REG_CTRL) begin
				ctrl_q <= {30'h0000_0000, reg_wdata[1:0]};
			end
			if (reg_wr && reg_addr == `PDS_REG_PACE) begin
				pace_q <= reg_wdata;
			end
			if (reg_rd) begin
				case (reg_addr)
					`PDS_REG_CTRL: begin
						reg_rdata <= ctrl_q;
					end
					`PDS_REG_PACE: begin
						reg_rdata <= pace_q;
					end
					`PDS_REG_STAT: begin
						reg_rdata <= status;
					end
					`PDS_REG_DISP: begin
						reg_rdata <= disp;
					end
					default: begin
						reg_rdata <= 32'h0000_0000;
					end
				endcase
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end
	end

endmodule // pds_sequencer

/* logic/pds_unused_guard.v */
/*
 * Holds no logic of the printer digit sequencer.
 */

/* tb/pds_printer_model.sv */
/* Digit printer model: strike linkage lag, then resume microswitch.
   Assumes lag stays below 240 cycles and solenoid is a level. */
module pds_printer_model (
	// Clock and reset
	input wire core_clk,
	input wire resetn,
	// Printer pins
	input wire solenoid,
	input wire [7:0] lag,
	output logic resume_start,
	output logic resume_idle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic run_q;
	always @(posedge core_clk) begin
		if (!resetn || !run_q) begin
			run_q <= resetn && solenoid;
			cnt_q <= 8'h0;
		end else begin
			cnt_q <= cnt_q + 8'h1;
			run_q <= cnt_q != lag + 8'h6;
		end
	end
	// Switch actuated for four cycles starting at the lag
	assign resume_start = run_q && cnt_q >= lag && cnt_q < lag + 8'h4;
	assign resume_idle = !resume_start;
endmodule // pds_printer_model

/* tb/pds_seq_sva.sv */
/* Port checker for pds_sequencer.
   Assumes it is bound onto the sequencer and sees its ports only. */
module pds_seq_sva (
	// Clock and reset
	input wire core_clk,
	input wire resetn,
	// Program sync and printer
	input wire wait_halt,
	input wire print_sync_n,
	input wire resume_start,
	input wire resume_idle,
	input wire [3:0] digit_out,
	input wire digit_valid,
	input wire solenoid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_sol_drop: assert property (solenoid && resume_start |-> ##[1:2] !solenoid)
		else $error("solenoid stays on after resume");
	a_sol_hold: assert property (solenoid && !resume_start |=> solenoid)
		else $error("solenoid dropped before resume");
	a_dig_idle: assert property (!digit_valid |-> digit_out == 4'h0)
		else $error("digit without translate");
	a_dig_steady: assert property (digit_valid && $past(digit_valid) |-> $stable(digit_out))
		else $error("digit changed while presented");
	a_strike_quiet: assert property (solenoid && $past(solenoid) |-> !digit_valid)
		else $error("digit presented during strike");
	a_sync_cause: assert property (!print_sync_n |-> wait_halt && resume_idle)
		else $error("completion pulse without cause");
	a_sync_pulse: assert property ($fell(print_sync_n) |=> print_sync_n)
		else $error("completion pulse too long");
	a_sync_sol: assert property (!print_sync_n |-> !solenoid)
		else $error("completion during strike");
	c_strike: cover property ($rose(solenoid));
	c_sync: cover property ($fell(print_sync_n));
	c_digit: cover property ($rose(digit_valid));
endmodule // pds_seq_sva

bind pds_sequencer pds_seq_sva u_pds_seq_sva (.core_clk(core_clk), .resetn(resetn),
	.wait_halt(wait_halt), .print_sync_n(print_sync_n), .resume_start(resume_start),
	.resume_idle(resume_idle), .digit_out(digit_out), .digit_valid(digit_valid),
	.solenoid(solenoid));

/* tb/tb.sv */
/* Self-checking bench for pds_sequencer with the printer model.
   Assumes the design sources and pds_map.vh are on the include path. */
`include "pds_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, wait_halt = 1;
	logic display_instruction = 0, plot_instruction = 0;
	logic [7:0] reg_addr = 0, lag = 3;
	logic [31:0] reg_wdata = 0, display_data = 0, reg_rdata, seed = 32'hf266a89f;
	logic [2:0] display_mode = 0;
	logic [3:0] digit_out;
	logic print_sync_n, resume_start, resume_idle, digit_valid, solenoid;
	logic rd_q = 0, chk = 0, dv_q = 0;
	int n_errors = 0, checked = 0, n_sync = 0;
	logic [3:0] dq[$];
	logic [31:0] rq[$];
	always #2 core_clk = ~core_clk;
	pds_sequencer #(.PACE_HALF(20)) u_pds_sequencer (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .display_instruction(display_instruction),
		.display_mode(display_mode), .display_data(display_data),
		.plot_instruction(plot_instruction), .wait_halt(wait_halt),
		.print_sync_n(print_sync_n), .resume_start(resume_start), .resume_idle(resume_idle),
		.digit_out(digit_out), .digit_valid(digit_valid), .solenoid(solenoid));
	pds_printer_model u_pds_printer_model (.core_clk(core_clk), .resetn(resetn),
		.solenoid(solenoid), .lag(lag), .resume_start(resume_start), .resume_idle(resume_idle));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic test_done();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic report(string what, logic [31:0] e, logic [31:0] g);
		checked++;
		if (e !== g) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check_reg(logic [31:0] e, logic [31:0] g);
		report("reg_rdata", e, g);
	endtask
	task automatic check_dig(logic [3:0] e, logic [3:0] g);
		report("digit_out", {28'h0, e}, {28'h0, g});
	endtask
	always @(posedge core_clk) begin
		rd_q <= reg_rd && chk;
		dv_q <= digit_valid;
		if (rd_q) check_reg(rq.pop_front(), reg_rdata);
		if (digit_valid === 1'b1 && !dv_q) begin
			if (dq.size() == 0) report("digit_count", 0, 1);
			else check_dig(dq.pop_front(), digit_out);
		end
		if (print_sync_n === 1'b0) n_sync++;
	end
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task automatic rd(logic [7:0] a, logic c, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		chk <= c;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task automatic rd_chk(logic [7:0] a, logic [31:0] e);
		logic [31:0] d;
		rq.push_back(e);
		rd(a, 1, d);
	endtask
	task automatic instr(logic p, logic [2:0] m, logic [31:0] d);
		@(posedge core_clk);
		plot_instruction <= p;
		display_instruction <= !p;
		display_mode <= m;
		display_data <= d;
		@(posedge core_clk);
		plot_instruction <= 0;
		display_instruction <= 0;
	endtask
	task automatic wait_for(ref logic s, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && s !== v; i++) @(posedge core_clk);
		if (i == lim) begin
			report("timeout", 0, 1);
			test_done();
		end
	endtask
	task automatic print(logic [2:0] m, logic [31:0] d, int nd, logic ab, logic [2:0] am, int es);
		logic [31:0] r;
		int k, s0;
		s0 = n_sync;
		for (k = 0; k < nd; k++)
			dq.push_back(m == `PDS_MODE_OCT ? {1'b0, d[23 - 3 * k -: 3]} : d[31 - 4 * k -: 4]);
		seed = xs(seed);
		lag <= seed[7:0] & 8'h3f;
		instr(0, m, d);
		for (k = 0; k < 3 && nd > 0; k++) begin
			wait_for(digit_valid, 1, 200);
			if (k < 2 && ab) wait_for(digit_valid, 0, 200);
		end
		if (ab) instr(am == 0, am, ~d);
		else if (nd > 0) instr(0, `PDS_MODE_DEC, ~d);
		wait_for(solenoid, 1, 1000);
		if (ab) begin
			rd(`PDS_REG_STAT, 0, r);
			check_reg(0, r & 32'h707c);
			rd_chk(`PDS_REG_DISP, 32'h0);
		end
		r = 1;
		for (k = 0; k < 400 && r !== 32'h0; k++) rd(`PDS_REG_STAT, 0, r);
		check_reg(0, r);
		if (r !== 32'h0) test_done();
		report("digits_left", 0, dq.size());
		report("print_sync_n", es, n_sync - s0);
	endtask
	initial begin
		int k;
		repeat (8) @(posedge core_clk);
		resetn <= 1;
		rd_chk(`PDS_REG_CTRL, `PDS_CTRL_RST);
		rd_chk(`PDS_REG_PACE, 32'd20);
		rd_chk(`PDS_REG_STAT, 32'h0);
		rd_chk(`PDS_REG_DISP, 32'h0);
		rd_chk(8'h10, 32'h0);
		wr(`PDS_REG_CTRL, 32'hffffffff);
		rd_chk(`PDS_REG_CTRL, 32'h3);
		wr(`PDS_REG_CTRL, 32'h2);
		print(`PDS_MODE_SPACE, 0, 0, 0, 0, 1);
		wr(`PDS_REG_CTRL, 32'h1);
		seed = xs(seed);
		print(`PDS_MODE_DEC, seed, 8, 0, 0, 1);
		wr(`PDS_REG_CTRL, 32'h0);
		seed = xs(seed);
		print(`PDS_MODE_OCT, seed, 8, 0, 0, 0);
		for (k = 0; k < 3; k++) begin
			wr(`PDS_REG_CTRL, 32'h3);
			wait_halt <= k != 1;
			seed = xs(seed);
			print(`PDS_MODE_DEC, seed, 3, 1, k == 0 ? 3'h0 : k == 1 ? `PDS_MODE_TGT
				: `PDS_MODE_MISS, k != 1);
		end
		test_done();
	end
endmodule // tb
